// [dv/cpu_sysif_tb.sv]
// Self-checking testbench for the processor system interface block.
`timescale 1ns/1ps
module cpu_sysif_tb;
	logic clk, rstn, ad_oe, chk_oe, cmd_oe, par_oe, par_o, pv_n, pq_n, own_n, flt_n, nmi_n, wrst_n, be, dv, pf;
	logic echo, tclk, txr, rdy, done, rxv, pend, nmit, rexc, me, prun, beo, snd, sb;
	logic ev_n, er_n, rdy_n, par_i, hold;
	logic [31:0] ad_i, ad_o, txw, rxw, sw;
	logic [4:0] cmd_i, cmd_o, txc, rxc, int_n, msk, sc;
	logic [3:0] chk_o, ms, pm, rw;
	logic [15:0] cause;
	int fail_count = 0;
	int n_compared = 0;

	cpu_sysif dut_u (.CLK_I(clk), .RESETN_I(rstn), .SHARED_ADDR_DATA_BUS_I(ad_i), .SHARED_ADDR_DATA_BUS_O(ad_o),
		.SHARED_ADDR_DATA_BUS_OE_O(ad_oe), .ADDR_DATA_CHECK_BITS_I(4'h0), .ADDR_DATA_CHECK_BITS_O(chk_o),
		.ADDR_DATA_CHECK_BITS_OE_O(chk_oe), .COMMAND_ID_BUS_I(cmd_i), .COMMAND_ID_BUS_O(cmd_o),
		.COMMAND_ID_BUS_OE_O(cmd_oe), .COMMAND_PARITY_BIT_I(par_i), .COMMAND_PARITY_BIT_O(par_o),
		.COMMAND_PARITY_BIT_OE_O(par_oe), .AGENT_VALID_STROBE_N_I(ev_n), .CPU_VALID_STROBE_N_O(pv_n),
		.AGENT_REQUEST_IN_N_I(er_n), .CPU_REQUEST_OUT_N_O(pq_n), .CPU_OWNS_BUS_N_O(own_n),
		.AGENT_CAN_ACCEPT_N_I(rdy_n), .FAULT_N_O(flt_n), .INT_N_I(int_n), .NMI_N_I(nmi_n),
		.WARM_RESET_N_I(wrst_n), .BYTE_ORDER_SELECT_I(be), .BUS_DIVISOR_SELECT_I(dv),
		.PARITY_FLOAT_SELECT_I(pf), .REF_CLOCK_ECHO_O(echo), .BUS_REF_CLOCK_OUT_O(tclk), .TX_REQ_I(txr),
		.TX_CMD_I(txc), .TX_WORD_I(txw), .TX_READY_O(rdy), .TX_DONE_O(done), .RX_VALID_O(rxv),
		.RX_CMD_O(rxc), .RX_WORD_O(rxw), .INT_MASK_I(msk), .IRQ_PENDING_O(pend), .NMI_TAKEN_O(nmit),
		.RESET_EXC_O(rexc), .CAUSE_O(cause), .MODE_ENTER_I(me), .MODE_SEL_I(ms), .POWER_MODE_O(pm),
		.PIPE_CLK_RUN_O(prun), .BIG_ENDIAN_O(beo));

	sysif_agent agent_u (.tclk_i(tclk), .dut_ad_i(ad_o), .dut_ad_oe_i(ad_oe), .dut_cmd_i(cmd_o),
		.dut_cmd_oe_i(cmd_oe), .dut_par_i(par_o), .dut_par_oe_i(par_oe), .dut_req_n_i(pq_n), .snd_i(snd),
		.s_cmd_i(sc), .s_word_i(sw), .s_bad_i(sb), .rdy_wait_i(rw), .ad_o(ad_i), .cmd_o(cmd_i), .par_o(par_i),
		.valid_n_o(ev_n), .req_n_o(er_n), .rdy_n_o(rdy_n), .hold_i(hold));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] swap(input logic [31:0] w);
		return be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset(input logic b, input logic d, input logic f);
		@(negedge clk);
		rstn = 1'b0;
		be = b;
		dv = d;
		pf = f;
		cyc(8);
		rstn = 1'b1;
		cyc(3);
	endtask

	// Counts rising edges of the transmit clock and the reference echo over 16 pipeline cycles.
	task automatic rises(input int et, input int ee);
		int t, e;
		logic pt, pe;
		t = 0;
		e = 0;
		pt = tclk;
		pe = echo;
		repeat (16) begin
			@(negedge clk);
			t += int'(tclk && !pt);
			e += int'(echo && !pe);
			pt = tclk;
			pe = echo;
		end
		chk("transmit clock rises", et, t);
		chk("echo clock rises", ee, e);
	endtask

	task automatic catch_pulse(input logic sel_rexc, input string nm);
		logic hit;
		hit = 1'b0;
		repeat (4) begin
			@(negedge clk);
			hit |= sel_rexc ? rexc : nmit;
		end
		chk(nm, 1, hit);
	endtask

	task automatic tx(input logic [4:0] c, input logic [31:0] w, input logic [3:0] wt);
		int n;
		logic [31:0] bw;
		bw = swap(w);
		rw = wt;
		txc = c;
		txw = w;
		txr = 1'b1;
		@(negedge clk);
		txr = 1'b0;
		n = 0;
		while (!ad_oe && n < 200) begin
			@(negedge clk);
			n++;
			if (n == 2 && wt != 0) chk("request low", 0, pq_n);
		end
		chk("waited for ready", 1, n >= 2 * wt);
		chk("bus driven", 1, ad_oe);
		chk("bus word", bw, ad_o);
		chk("command enable", 1, cmd_oe);
		chk("command", c, cmd_o);
		chk("valid", 0, pv_n);
		chk("owns bus", 0, own_n);
		chk("parity enable", !pf, par_oe);
		chk("check enable", !pf, chk_oe);
		if (!pf) chk("parity", ^c, par_o);
		if (!pf) chk("check bits", {^bw[31:24], ^bw[23:16], ^bw[15:8], ^bw[7:0]}, chk_o);
		n = 1;
		while (ad_oe && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("drive cycles", dv ? 2 : 4, n - 1);
		chk("done", 1, done);
		chk("owns released", 1, own_n);
	endtask

	task automatic rx(input logic [4:0] c, input logic [31:0] w, input logic b);
		int n;
		sc = c;
		sw = w;
		sb = b;
		snd = 1'b1;
		n = 0;
		while (!rxv && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk("rx valid", 1, rxv);
		snd = 1'b0;
		chk("rx command", c, rxc);
		chk("rx word", swap(w), rxw);
		chk("fault", !(b && !pf), flt_n);
		cyc(10);
	endtask

	task automatic enter(input logic [3:0] m);
		ms = m;
		me = 1'b1;
		@(negedge clk);
		me = 1'b0;
		cyc(3);
		chk("mode", m, pm);
	endtask

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		fail_count++;
		test_done();
	end

	initial begin
		{rstn, be, dv, pf, txr, me, snd, sb} = '0;
		{nmi_n, wrst_n} = 2'b11;
		int_n = 5'h1f;
		msk = 5'h00;
		{txc, sc} = '0;
		{txw, sw} = '0;
		ms = 4'h0;
		rw = 4'h0;
		hold = 1'b0;
		do_reset(1'b0, 1'b0, 1'b0);
		chk("reset drive", 0, ad_oe);
		chk("reset fault", 1, flt_n);
		chk("reset mode", 4'h1, pm);
		chk("ready", 1, rdy);
		chk("byte order", 0, beo);
		rises(4, 4);
		tx(5'h03, 32'h1234_5678, 4'h0);
		tx(5'h1c, 32'h8000_00ff, 4'h4);
		hold = 1'b1;
		tx(5'h05, 32'h0bad_cafe, 4'h3);
		hold = 1'b0;
		rx(5'h06, 32'ha5a5_0f0f, 1'b0);
		rx(5'h07, 32'h0000_0001, 1'b1);
		$display("test bus transfers done");
		int_n = 5'h0a;
		msk = 5'h01;
		cyc(3);
		chk("cause", 16'h5400, cause);
		chk("pending", 1, pend);
		msk = 5'h0a;
		cyc(3);
		chk("masked", 0, pend);
		int_n = 5'h1f;
		msk = 5'h00;
		nmi_n = 1'b0;
		catch_pulse(1'b0, "nmi taken");
		nmi_n = 1'b1;
		wrst_n = 1'b0;
		catch_pulse(1'b1, "reset exception");
		wrst_n = 1'b1;
		chk("kept order", 0, beo);
		$display("test interrupts done");
		enter(4'h2);
		chk("pipe stopped", 0, prun);
		chk("not ready", 0, rdy);
		rises(4, 4);
		int_n = 5'h1e;
		cyc(3);
		int_n = 5'h1f;
		chk("woken", 4'h1, pm);
		enter(4'h4);
		rises(0, 4);
		nmi_n = 1'b0;
		cyc(3);
		nmi_n = 1'b1;
		chk("woken", 4'h1, pm);
		enter(4'h8);
		rises(0, 0);
		int_n = 5'h00;
		cyc(3);
		int_n = 5'h1f;
		chk("still asleep", 4'h8, pm);
		$display("test power modes done");
		do_reset(1'b1, 1'b1, 1'b1);
		chk("mode after reset", 4'h1, pm);
		chk("byte order", 1, beo);
		rises(8, 4);
		tx(5'h11, 32'hdead_0123, 4'h1);
		rx(5'h01, 32'h0102_0304, 1'b1);
		$display("test straps done");
		test_done();
	end
endmodule

// [dv/sysif_agent.sv]
// Behavioural external agent on the far side of the processor system interface.
`timescale 1ns/1ps
module sysif_agent (
	input wire logic tclk_i,
	input wire logic [31:0] dut_ad_i,
	input wire logic dut_ad_oe_i,
	input wire logic [4:0] dut_cmd_i,
	input wire logic dut_cmd_oe_i,
	input wire logic dut_par_i,
	input wire logic dut_par_oe_i,
	input wire logic dut_req_n_i,
	input wire logic snd_i,
	input wire logic [4:0] s_cmd_i,
	input wire logic [31:0] s_word_i,
	input wire logic s_bad_i,
	input wire logic [3:0] rdy_wait_i,
	input wire logic hold_i,
	output logic [31:0] ad_o,
	output logic [4:0] cmd_o,
	output logic par_o,
	output logic valid_n_o,
	output logic req_n_o,
	output logic rdy_n_o
);
	logic drv = 1'b0;
	logic sent = 1'b0;
	logic p = 1'b0;
	logic [31:0] w = 32'h0;
	logic [4:0] c = 5'h0;
	logic [3:0] wcnt = 4'h0;

	// Words change just after a transmit clock rise and hold one whole bus period.
	always @(posedge tclk_i) begin
		sent <= snd_i;
		if (drv) begin
			drv <= 1'b0;
		end else if (snd_i && !sent) begin
			drv <= 1'b1;
			w <= s_word_i;
			c <= s_cmd_i;
			p <= ^s_cmd_i ^ s_bad_i;
		end
		if (dut_req_n_i)
			wcnt <= 4'h0;
		else if (wcnt != rdy_wait_i)
			wcnt <= wcnt + 4'h1;
	end

	// Nobody holds an undriven line, so it shows the inverse of the last value, not a stale copy.
	assign ad_o = dut_ad_oe_i ? dut_ad_i : (drv ? w : ~w);
	assign cmd_o = dut_cmd_oe_i ? dut_cmd_i : (drv ? c : ~c);
	assign par_o = dut_par_oe_i ? dut_par_i : (drv ? p : ~p);
	assign valid_n_o = !drv;
	// In hold mode the agent is ready at once but keeps the bus by its own request for the wait.
	assign req_n_o = !(hold_i && !dut_req_n_i && (wcnt != rdy_wait_i));
	assign rdy_n_o = dut_req_n_i | (!hold_i && (wcnt != rdy_wait_i));
endmodule

// [logic/cpu_sysif.sv]
// System interface pins, straps, interrupt inputs and clock generation of the processor.
`timescale 1ns/1ps
module cpu_sysif (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [cpu_sysif_pkg::AD_W-1:0] SHARED_ADDR_DATA_BUS_I,
	output logic [cpu_sysif_pkg::AD_W-1:0] SHARED_ADDR_DATA_BUS_O,
	output logic SHARED_ADDR_DATA_BUS_OE_O,
	input wire logic [cpu_sysif_pkg::CHK_W-1:0] ADDR_DATA_CHECK_BITS_I,
	output logic [cpu_sysif_pkg::CHK_W-1:0] ADDR_DATA_CHECK_BITS_O,
	output logic ADDR_DATA_CHECK_BITS_OE_O,
	input wire logic [cpu_sysif_pkg::CMD_W-1:0] COMMAND_ID_BUS_I,
	output logic [cpu_sysif_pkg::CMD_W-1:0] COMMAND_ID_BUS_O,
	output logic COMMAND_ID_BUS_OE_O,
	input wire logic COMMAND_PARITY_BIT_I,
	output logic COMMAND_PARITY_BIT_O,
	output logic COMMAND_PARITY_BIT_OE_O,
	input wire logic AGENT_VALID_STROBE_N_I,
	output logic CPU_VALID_STROBE_N_O,
	input wire logic AGENT_REQUEST_IN_N_I,
	output logic CPU_REQUEST_OUT_N_O,
	output logic CPU_OWNS_BUS_N_O,
	input wire logic AGENT_CAN_ACCEPT_N_I,
	output logic FAULT_N_O,
	input wire logic [cpu_sysif_pkg::IRQ_W-1:0] INT_N_I,
	input wire logic NMI_N_I,
	input wire logic WARM_RESET_N_I,
	input wire logic BYTE_ORDER_SELECT_I,
	input wire logic BUS_DIVISOR_SELECT_I,
	input wire logic PARITY_FLOAT_SELECT_I,
	output logic REF_CLOCK_ECHO_O,
	output logic BUS_REF_CLOCK_OUT_O,
	input wire logic TX_REQ_I,
	input wire logic [cpu_sysif_pkg::CMD_W-1:0] TX_CMD_I,
	input wire logic [cpu_sysif_pkg::AD_W-1:0] TX_WORD_I,
	output logic TX_READY_O,
	output logic TX_DONE_O,
	output logic RX_VALID_O,
	output logic [cpu_sysif_pkg::CMD_W-1:0] RX_CMD_O,
	output logic [cpu_sysif_pkg::AD_W-1:0] RX_WORD_O,
	input wire logic [cpu_sysif_pkg::IRQ_W-1:0] INT_MASK_I,
	output logic IRQ_PENDING_O,
	output logic NMI_TAKEN_O,
	output logic RESET_EXC_O,
	output logic [cpu_sysif_pkg::CAUSE_W-1:0] CAUSE_O,
	input wire logic MODE_ENTER_I,
	input wire logic [3:0] MODE_SEL_I,
	output logic [3:0] POWER_MODE_O,
	output logic PIPE_CLK_RUN_O,
	output logic BIG_ENDIAN_O
);
	import cpu_sysif_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic [CHK_W-1:0] check_bits(input logic [AD_W-1:0] w);
		logic [CHK_W-1:0] c;
		c = RST_CHK;
		for (int i = 0; i < CHK_W; i++) begin
			c[i] = ^w[8*i +: 8];
		end
		return c;
	endfunction

	function automatic logic [AD_W-1:0] order_bytes(input logic big, input logic [AD_W-1:0] w);
		return big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction

	// ****************************************************************
	// Straps
	// ****************************************************************
	// Straps are caught on the first edge after cold reset release, never by the reset itself.
	logic strap_done_r;
	logic big_endian_r;
	logic div_fast_r;
	logic par_float_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			strap_done_r <= 1'b0;
			big_endian_r <= RST_BIG_ENDIAN;
			div_fast_r <= RST_DIV_FAST;
			par_float_r <= RST_PAR_FLOAT;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			big_endian_r <= BYTE_ORDER_SELECT_I;
			div_fast_r <= BUS_DIVISOR_SELECT_I;
			par_float_r <= PARITY_FLOAT_SELECT_I;
		end
	end

	// ****************************************************************
	// Power modes
	// ****************************************************************
	pm_state_t pm_r;
	pm_state_t pm_nxt;
	pm_state_t pm_pend_r;
	logic pend_r;
	bus_state_t st_r;
	bus_state_t st_nxt;
	logic nmi_prev_r;
	logic warm_prev_r;
	wire nmi_edge = nmi_prev_r && !NMI_N_I;
	wire warm_edge = warm_prev_r && !WARM_RESET_N_I;
	wire irq_any = |(~INT_N_I);
	wire wake = irq_any || nmi_edge || warm_edge;
	wire legal_sel = (MODE_SEL_I == PM_STANDBY) || (MODE_SEL_I == PM_SUSPEND) || (MODE_SEL_I == PM_HIBERNATE);
	// A low-power mode is entered only once the bus has gone idle.
	wire may_enter = pend_r && (st_r == ST_IDLE) && !TX_REQ_I;

	always_comb begin
		pm_nxt = pm_r;
		unique case (pm_r)
			PM_FULL: begin
				if (may_enter) begin
					pm_nxt = pm_pend_r;
				end
			end
			PM_STANDBY, PM_SUSPEND: begin
				if (wake) begin
					pm_nxt = PM_FULL;
				end
			end
			PM_HIBERNATE: begin
				pm_nxt = PM_HIBERNATE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pm_r <= PM_FULL;
			pm_pend_r <= PM_FULL;
			pend_r <= 1'b0;
		end else begin
			pm_r <= pm_nxt;
			if (pm_r == PM_FULL && MODE_ENTER_I && legal_sel) begin
				pend_r <= 1'b1;
				pm_pend_r <= pm_state_t'(MODE_SEL_I);
			end else if (may_enter) begin
				pend_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Clock generation
	// ****************************************************************
	// Bus and echo clocks are divided from CLK_I so that all logic stays in one domain.
	logic [1:0] echo_cnt_r;
	logic echo_r;
	logic [1:0] bus_cnt_r;
	logic bclk_r;
	wire echo_run = (pm_r != PM_HIBERNATE);
	wire bus_run = (pm_r == PM_FULL) || (pm_r == PM_STANDBY);
	wire [1:0] bus_tc = div_fast_r ? BUS_TC_FAST : BUS_TC_SLOW;
	wire bus_flip = bus_run && (bus_cnt_r == bus_tc);
	wire bus_tick = bus_flip && !bclk_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			echo_cnt_r <= RST_CNT;
			echo_r <= 1'b0;
			bus_cnt_r <= RST_CNT;
			bclk_r <= 1'b0;
		end else begin
			echo_cnt_r <= (!echo_run || echo_cnt_r == ECHO_TC) ? RST_CNT : echo_cnt_r + 2'h1;
			echo_r <= echo_run && (echo_r ^ (echo_cnt_r == ECHO_TC));
			bus_cnt_r <= (!bus_run || bus_flip) ? RST_CNT : bus_cnt_r + 2'h1;
			bclk_r <= bus_run && (bclk_r ^ bus_flip);
		end
	end

	assign REF_CLOCK_ECHO_O = echo_r;
	assign BUS_REF_CLOCK_OUT_O = bclk_r;
	// Full speed is the one-hot bit 0, so the run flag comes straight from the mode flop.
	assign PIPE_CLK_RUN_O = pm_r[0];
	assign POWER_MODE_O = pm_r;
	assign BIG_ENDIAN_O = big_endian_r;

	a_hib_stopped: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$past(pm_r) == PM_HIBERNATE |-> !echo_r && !bclk_r)
		else $error("clock running in hibernate");
	a_echo_period: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$rose(echo_r) && pm_r == PM_FULL |-> ##4 ($rose(echo_r) || pm_r == PM_HIBERNATE))
		else $error("echo clock not a quarter of CLK_I");

	// ****************************************************************
	// Bus transfer state machine
	// ****************************************************************
	logic [CMD_W-1:0] tx_cmd_r;
	logic [AD_W-1:0] tx_word_r;
	wire agent_ready = !AGENT_CAN_ACCEPT_N_I;
	wire agent_wants = !AGENT_REQUEST_IN_N_I;
	wire agent_valid = !AGENT_VALID_STROBE_N_I;
	wire [AD_W-1:0] drive_word = order_bytes(big_endian_r, tx_word_r);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (TX_REQ_I && pm_r == PM_FULL) begin
					st_nxt = ST_REQ;
				end
			end
			ST_REQ: begin
				// The agent keeps the bus while it asks for it.
				if (bus_tick && agent_ready && !agent_wants && !agent_valid) begin
					st_nxt = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (bus_tick) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	logic drive_r;
	logic valid_n_r;
	logic req_n_r;
	logic owns_n_r;
	logic [AD_W-1:0] ad_o_r;
	logic [CHK_W-1:0] chk_o_r;
	logic chk_oe_r;
	logic [CMD_W-1:0] cmd_o_r;
	logic cmdp_o_r;
	logic cmdp_oe_r;
	logic ready_r;
	logic done_r;
	wire start_drive = (st_r == ST_REQ) && (st_nxt == ST_DRIVE);

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_r <= ST_IDLE;
			tx_cmd_r <= RST_CMD;
			tx_word_r <= RST_WORD;
			drive_r <= 1'b0;
			valid_n_r <= 1'b1;
			req_n_r <= 1'b1;
			owns_n_r <= 1'b1;
			ad_o_r <= RST_WORD;
			chk_o_r <= RST_CHK;
			chk_oe_r <= 1'b0;
			cmd_o_r <= RST_CMD;
			cmdp_o_r <= 1'b0;
			cmdp_oe_r <= 1'b0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE && st_nxt == ST_REQ) begin
				tx_cmd_r <= TX_CMD_I;
				tx_word_r <= TX_WORD_I;
			end
			req_n_r <= !(st_nxt == ST_REQ);
			drive_r <= st_nxt == ST_DRIVE;
			owns_n_r <= !(st_nxt == ST_DRIVE);
			valid_n_r <= !(st_nxt == ST_DRIVE);
			chk_oe_r <= st_nxt == ST_DRIVE && !par_float_r;
			cmdp_oe_r <= st_nxt == ST_DRIVE && !par_float_r;
			if (start_drive) begin
				ad_o_r <= drive_word;
				chk_o_r <= check_bits(drive_word);
				cmd_o_r <= tx_cmd_r;
				cmdp_o_r <= ^tx_cmd_r;
			end
			ready_r <= st_nxt == ST_IDLE && pm_nxt == PM_FULL;
			done_r <= st_r == ST_DRIVE && st_nxt == ST_IDLE;
		end
	end

	assign SHARED_ADDR_DATA_BUS_O = ad_o_r;
	assign SHARED_ADDR_DATA_BUS_OE_O = drive_r;
	assign ADDR_DATA_CHECK_BITS_O = chk_o_r;
	assign ADDR_DATA_CHECK_BITS_OE_O = chk_oe_r;
	assign COMMAND_ID_BUS_O = cmd_o_r;
	assign COMMAND_ID_BUS_OE_O = drive_r;
	assign COMMAND_PARITY_BIT_O = cmdp_o_r;
	assign COMMAND_PARITY_BIT_OE_O = cmdp_oe_r;
	assign CPU_VALID_STROBE_N_O = valid_n_r;
	assign CPU_REQUEST_OUT_N_O = req_n_r;
	assign CPU_OWNS_BUS_N_O = owns_n_r;
	assign TX_READY_O = ready_r;
	assign TX_DONE_O = done_r;

	a_owner_drive: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!owns_n_r == drive_r && drive_r == !valid_n_r)
		else $error("ownership differs from driving");
	a_cmd_even: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		cmdp_oe_r |-> (^{cmd_o_r, cmdp_o_r}) == 1'b0)
		else $error("command parity not even");
	a_check_bits: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		chk_oe_r |-> chk_o_r == check_bits(ad_o_r) && drive_r)
		else $error("check bits do not match driven word");
	a_float_parity: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		strap_done_r && par_float_r |=> !chk_oe_r && !cmdp_oe_r)
		else $error("parity outputs driven while floated");
	a_issue_ready: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$rose(drive_r) |-> $past(agent_ready) && !$past(agent_wants) && !req_n_r == 1'b0)
		else $error("issued without agent ready");
	a_req_held: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$past(st_r) == ST_REQ && st_r == ST_REQ |-> !req_n_r)
		else $error("request dropped while waiting");

	// ****************************************************************
	// Receive path and command parity check
	// ****************************************************************
	logic rx_valid_r;
	logic [CMD_W-1:0] rx_cmd_r;
	logic [AD_W-1:0] rx_word_r;
	logic fault_n_r;
	wire rx_take = bus_tick && agent_valid && (st_r != ST_DRIVE);
	wire cmd_bad = ^{COMMAND_ID_BUS_I, COMMAND_PARITY_BIT_I};

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_valid_r <= 1'b0;
			rx_cmd_r <= RST_CMD;
			rx_word_r <= RST_WORD;
			fault_n_r <= 1'b1;
		end else begin
			rx_valid_r <= rx_take;
			if (rx_take) begin
				rx_cmd_r <= COMMAND_ID_BUS_I;
				rx_word_r <= order_bytes(big_endian_r, SHARED_ADDR_DATA_BUS_I);
			end
			// The fault level stands for one bus clock period.
			if (bus_tick || par_float_r) begin
				fault_n_r <= !(rx_take && cmd_bad && !par_float_r);
			end
		end
	end

	assign RX_VALID_O = rx_valid_r;
	assign RX_CMD_O = rx_cmd_r;
	assign RX_WORD_O = rx_word_r;
	assign FAULT_N_O = fault_n_r;

	a_fault_quiet: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		strap_done_r && par_float_r |=> fault_n_r)
		else $error("fault raised while parity floated");
	a_fault_raise: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		rx_take && cmd_bad && !par_float_r |=> !fault_n_r)
		else $error("parity error not reported");

	// ****************************************************************
	// Interrupts and warm reset
	// ****************************************************************
	logic [CAUSE_W-1:0] cause_r;
	logic irq_pend_r;
	logic nmi_taken_r;
	logic reset_exc_r;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cause_r <= RST_CAUSE;
			irq_pend_r <= 1'b0;
			nmi_taken_r <= 1'b0;
			reset_exc_r <= 1'b0;
			nmi_prev_r <= 1'b1;
			warm_prev_r <= 1'b1;
		end else begin
			cause_r[CAUSE_IRQ_MSB:CAUSE_IRQ_LSB] <= ~INT_N_I;
			irq_pend_r <= (~INT_N_I & INT_MASK_I) != IRQ_NONE;
			nmi_prev_r <= NMI_N_I;
			warm_prev_r <= WARM_RESET_N_I;
			// No mask term here: the non-maskable request is never gated.
			nmi_taken_r <= nmi_edge;
			// Warm reset flags the exception and also wakes standby or suspend; no other state is cleared.
			reset_exc_r <= warm_edge;
		end
	end

	assign CAUSE_O = cause_r;
	assign IRQ_PENDING_O = irq_pend_r;
	assign NMI_TAKEN_O = nmi_taken_r;
	assign RESET_EXC_O = reset_exc_r;

	a_cause_bits: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		##1 CAUSE_O[CAUSE_IRQ_MSB:CAUSE_IRQ_LSB] == ~$past(INT_N_I))
		else $error("cause bits do not follow interrupt inputs");
	a_nmi_taken: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		$fell(NMI_N_I) |=> nmi_taken_r)
		else $error("non-maskable request not taken");
	a_warm_keeps: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		warm_edge |=> reset_exc_r && $stable(big_endian_r) && $stable(tx_word_r))
		else $error("warm reset lost or cleared state");

endmodule

// [logic/cpu_sysif_pkg.sv]
// Shared constants and types for the processor system interface block.
package cpu_sysif_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int AD_W = 32;
	localparam int CHK_W = 4;
	localparam int CMD_W = 5;
	localparam int IRQ_W = 5;
	localparam int CAUSE_W = 16;
	localparam int CAUSE_IRQ_LSB = 10;
	localparam int CAUSE_IRQ_MSB = 14;

	// ****************************************************************
	// Clock generation counts, in CLK_I cycles
	// ****************************************************************
	// CLK_I is the pipeline clock, four times the reference clock.
	localparam int PIPE_PER_REF = 4;
	localparam logic [1:0] ECHO_TC = 2'((PIPE_PER_REF / 2) - 1);
	localparam int BUS_RATIO_FAST = 2;
	localparam int BUS_RATIO_SLOW = 4;
	localparam logic [1:0] BUS_TC_FAST = 2'((BUS_RATIO_FAST / 2) - 1);
	localparam logic [1:0] BUS_TC_SLOW = 2'((BUS_RATIO_SLOW / 2) - 1);

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic RST_BIG_ENDIAN = 1'b0;
	localparam logic RST_DIV_FAST = 1'b0;
	localparam logic RST_PAR_FLOAT = 1'b0;
	localparam logic [AD_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [CMD_W-1:0] RST_CMD = 5'h00;
	localparam logic [CHK_W-1:0] RST_CHK = 4'h0;
	localparam logic [1:0] RST_CNT = 2'h0;
	localparam logic [CAUSE_W-1:0] RST_CAUSE = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_NONE = 5'h00;

	// ****************************************************************
	// State encodings
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_REQ = 3'b010,
		ST_DRIVE = 3'b100
	} bus_state_t;

	typedef enum logic [3:0] {
		PM_FULL = 4'b0001,
		PM_STANDBY = 4'b0010,
		PM_SUSPEND = 4'b0100,
		PM_HIBERNATE = 4'b1000
	} pm_state_t;

endpackage
